// ==== shared/canfd_rx_pkg.sv ====
// Package of register map, field positions and timing constants for the CAN FD receive status block
package canfd_rx_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000; // Operating mode
  localparam logic [11:0] OFF_CLEAR     = 12'h004; // Buffer clear control
  localparam logic [11:0] OFF_OVF       = 12'h008; // Buffer overflow status
  localparam logic [11:0] OFF_STATUS    = 12'h00C; // Bus error state
  localparam logic [11:0] OFF_ERRCNT    = 12'h010; // Tx count [16:8], rx count [7:0]
  localparam logic [11:0] OFF_RX_MESSAGE_COUNT    = 12'h014; // Frames waiting
  localparam logic [11:0] OFF_POP       = 12'h018; // Write: release head frame
  localparam logic [11:0] OFF_FRAME     = 12'h01C; // Head id, format and type
  localparam logic [11:0] OFF_TS_LO     = 12'h020;
  localparam logic [11:0] OFF_TS_HI     = 12'h024;
  localparam logic [11:0] OFF_BYTES     = 12'h028; // Payload byte count
  localparam logic [11:0] OFF_DATA      = 12'h040; // 16 words of payload
  localparam logic [11:0] OFF_DATA_END  = 12'h07C;

  // ==========================================================
  // Field positions
  localparam int BIT_CLR_RX   = 0;
  localparam int BIT_CLR_TX   = 1;
  localparam int BIT_WARN_ANY = 0;
  localparam int BIT_WARN_RX  = 1;
  localparam int BIT_WARN_TX  = 2;
  localparam int BIT_PASS_RX  = 3;
  localparam int BIT_PASS_TX  = 4;
  localparam int BIT_BUS_OFF  = 5;
  localparam int FRM_FMT_BIT  = 29;
  localparam int FRM_TYPE_LSB = 30;

  // ==========================================================
  // Thresholds and sizes
  localparam logic [8:0] WARN_LIMIT    = 9'd95;
  localparam logic [8:0] PASSIVE_LIMIT = 9'd127;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'd255;
  localparam logic [10:0] STD_ID_MAX   = 11'h7FF;
  localparam int PAYLOAD_BYTES = 64;
  localparam int DEPTH         = 4;
  localparam int PTR_W         = 2;
  localparam logic [3:0] CLASSIC_DLC_MAX = 4'h8;

  // ==========================================================
  // Timestamp tick: 100 ns at a 10 MHz clock
  localparam int TICK_NS      = 100;
  localparam int CLK_NS       = 100;
  localparam int TICK_CYCLES  = (TICK_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    MODE_FD     = 2'b00,
    MODE_CLASSIC= 2'b01,
    MODE_LISTEN = 2'b10,
    MODE_CONFIG = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    FT_REMOTE   = 2'b00,
    FT_CLASSIC  = 2'b01,
    FT_FD       = 2'b10,
    FT_FD_BRS   = 2'b11
  } frame_type_t;

endpackage

// ==== logic/canfd_rx_status_buffers.sv ====
// Receive descriptor store, buffer clear and bus error state for one CAN FD port
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

module canfd_rx_status_buffers (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        rx_valid,
  input  wire logic                        rx_ext_id,
  input  wire logic [28:0]                 rx_id,
  input  wire canfd_rx_pkg::frame_type_t   rx_type,
  input  wire logic [3:0]                  rx_dlc,
  input  wire logic [511:0]                rx_data,
  input  wire logic                        tx_overflow_event,
  input  wire logic [8:0]                  tx_error_count,
  input  wire logic [7:0]                  rx_error_count,
  output logic                             clear_tx_buffer,
  output canfd_rx_pkg::op_mode_t           op_mode
);
  import canfd_rx_pkg::*;

  // ==========================================================
  // Helpers
  // Length code to byte count
  function automatic logic [6:0] dlc_bytes(input logic [3:0] code);
    case (code)
      4'h9:    dlc_bytes = 7'd12;
      4'hA:    dlc_bytes = 7'd16;
      4'hB:    dlc_bytes = 7'd20;
      4'hC:    dlc_bytes = 7'd24;
      4'hD:    dlc_bytes = 7'd32;
      4'hE:    dlc_bytes = 7'd48;
      4'hF:    dlc_bytes = 7'd64;
      default: dlc_bytes = {3'b000, code};
    endcase
  endfunction

  // ==========================================================
  // Storage
  logic [28:0]           id_mem   [DEPTH];
  logic                  ext_mem  [DEPTH];
  frame_type_t           type_mem [DEPTH];
  logic [3:0]            dlc_mem  [DEPTH];
  logic [511:0]          data_mem [DEPTH];
  logic [63:0]           ts_mem   [DEPTH];
  logic [PTR_W-1:0]      wr_ptr_reg;
  logic [PTR_W-1:0]      rd_ptr_reg;
  logic [PTR_W:0]        count_reg;
  logic [63:0]           ts_reg;
  logic [PTR_W-1:0]      tick_reg;
  logic                  rx_ovf_reg;
  logic                  tx_ovf_reg;
  op_mode_t              mode_reg;
  logic                  clear_tx_reg;

  // Bus decode strobes
  logic                  acc;
  logic                  wr;
  logic                  clr_rx;
  logic                  clr_tx;
  logic                  pop;
  logic                  push;
  logic                  full;
  logic                  bad_frame;
  logic [3:0]            dlc_fix;
  logic [15:0]           status_word;
  logic [31:0]           rdata_next;
  logic                  mapped;

  assign acc     = psel && penable && clk_en;
  assign wr      = acc && pwrite;
  assign clr_rx  = wr && (paddr == OFF_CLEAR) && pwdata[BIT_CLR_RX];
  assign clr_tx  = wr && (paddr == OFF_CLEAR) && pwdata[BIT_CLR_TX];
  assign pop     = wr && (paddr == OFF_POP) && (count_reg != '0);
  assign full    = (count_reg == (PTR_W+1)'(DEPTH));
  // A standard id above its 11-bit range is malformed and dropped silently
  assign bad_frame = (!rx_ext_id && (rx_id > {18'h0, STD_ID_MAX}));
  // A full store still takes a frame when the head is released in the same cycle
  assign push    = clk_en && rx_valid && (!full || pop) && !clr_rx && !bad_frame;
  // Classic frames are clamped so the stored code stays in 0..8
  assign dlc_fix = ((rx_type == FT_REMOTE || rx_type == FT_CLASSIC) && rx_dlc > CLASSIC_DLC_MAX)
                   ? CLASSIC_DLC_MAX : rx_dlc;

  // ==========================================================
  // Timestamp counter, one step per 100 ns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_reg   <= 64'h0;
      tick_reg <= '0;
    end else if (clk_en) begin
      if (tick_reg == PTR_W'(TICK_CYCLES - 1)) begin
        tick_reg <= '0;
        ts_reg   <= ts_reg + 64'h1;
      end else begin
        tick_reg <= tick_reg + PTR_W'(1);
      end
    end
  end

  // Frame store write; payload zeroed for remote frames so it never leaks old data
  always_ff @(posedge pclk) begin
    if (push) begin
      id_mem[wr_ptr_reg]   <= rx_id;
      ext_mem[wr_ptr_reg]  <= rx_ext_id;
      type_mem[wr_ptr_reg] <= rx_type;
      dlc_mem[wr_ptr_reg]  <= dlc_fix;
      data_mem[wr_ptr_reg] <= (rx_type == FT_REMOTE) ? 512'h0 : rx_data;
      ts_mem[wr_ptr_reg]   <= ts_reg;
    end
  end

  // Pointers and waiting count; clear empties the store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en) begin
      if (clr_rx) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (push)
          wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
        if (pop)
          rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
        if (push && !pop)
          count_reg <= count_reg + (PTR_W+1)'(1);
        else if (pop && !push)
          count_reg <= count_reg - (PTR_W+1)'(1);
      end
    end
  end

  // Overflow flags are sticky; a new overflow in the clear cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ovf_reg <= 1'b0;
      tx_ovf_reg <= 1'b0;
    end else if (clk_en) begin
      if (rx_valid && !bad_frame && full && !pop)
        rx_ovf_reg <= 1'b1;
      else if (clr_rx)
        rx_ovf_reg <= 1'b0;
      if (tx_overflow_event)
        tx_ovf_reg <= 1'b1;
      else if (clr_tx)
        tx_ovf_reg <= 1'b0;
    end
  end

  // Mode register and one-cycle transmit clear pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg     <= MODE_CONFIG;
      clear_tx_reg <= 1'b0;
    end else if (clk_en) begin
      clear_tx_reg <= clr_tx;
      if (wr && paddr == OFF_CTRL)
        mode_reg <= op_mode_t'(pwdata[1:0]);
    end
  end

  assign op_mode         = mode_reg;
  assign clear_tx_buffer = clear_tx_reg;

  // ==========================================================
  // Error state decode from the live counters
  always_comb begin
    status_word = 16'h0000;
    status_word[BIT_WARN_RX] = ({1'b0, rx_error_count} > WARN_LIMIT) &&
                               ({1'b0, rx_error_count} <= PASSIVE_LIMIT);
    status_word[BIT_WARN_TX] = (tx_error_count > WARN_LIMIT) && (tx_error_count <= PASSIVE_LIMIT);
    status_word[BIT_WARN_ANY] = status_word[BIT_WARN_RX] || status_word[BIT_WARN_TX];
    status_word[BIT_PASS_RX] = ({1'b0, rx_error_count} > PASSIVE_LIMIT);
    status_word[BIT_PASS_TX] = (tx_error_count > PASSIVE_LIMIT);
    status_word[BIT_BUS_OFF] = (tx_error_count > BUSOFF_LIMIT) || (mode_reg == MODE_CONFIG);
  end

  // ==========================================================
  // APB read mux; unmapped addresses answer with an error
  always_comb begin
    rdata_next = 32'h0000_0000;
    mapped     = 1'b1;
    if (paddr == OFF_CTRL)
      rdata_next = {30'h0, mode_reg};
    else if (paddr == OFF_CLEAR || paddr == OFF_POP)
      rdata_next = 32'h0000_0000;
    else if (paddr == OFF_OVF)
      rdata_next = {30'h0, tx_ovf_reg, rx_ovf_reg};
    else if (paddr == OFF_STATUS)
      rdata_next = {16'h0, status_word};
    else if (paddr == OFF_ERRCNT)
      rdata_next = {15'h0, tx_error_count, rx_error_count};
    else if (paddr == OFF_RX_MESSAGE_COUNT)
      rdata_next = {{(31-PTR_W){1'b0}}, count_reg};
    else if (paddr == OFF_FRAME)
      rdata_next = {type_mem[rd_ptr_reg], ext_mem[rd_ptr_reg], id_mem[rd_ptr_reg]};
    else if (paddr == OFF_TS_LO)
      rdata_next = ts_mem[rd_ptr_reg][31:0];
    else if (paddr == OFF_TS_HI)
      rdata_next = ts_mem[rd_ptr_reg][63:32];
    else if (paddr == OFF_BYTES)
      rdata_next = {21'h0, dlc_mem[rd_ptr_reg], dlc_bytes(dlc_mem[rd_ptr_reg])};
    else if (paddr >= OFF_DATA && paddr <= OFF_DATA_END && paddr[1:0] == 2'b00)
      rdata_next = data_mem[rd_ptr_reg][{paddr[5:2], 5'b00000} +: 32];
    else
      mapped = 1'b0;
  end

  // Read data registered at the end of the setup phase; single-cycle access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && clk_en) begin
      prdata  <= rdata_next;
    end
  end

  assign pready  = clk_en;
  assign pslverr = acc && !mapped;

  // ==========================================================
  // Checks
  // Arrival and release steps named once, each used by one overflow, store or count check
  sequence full_arrival_s;
    rx_valid && full && !pop && !clr_rx && !bad_frame;
  endsequence

  sequence remote_push_s;
    push && rx_type == FT_REMOTE;
  endsequence

  sequence classic_push_s;
    push && (rx_type == FT_REMOTE || rx_type == FT_CLASSIC);
  endsequence

  sequence pop_only_s;
    pop && !push && !clr_rx;
  endsequence

  // Store, clear and overflow flags
  rx_overflow_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en and full_arrival_s) |=> rx_ovf_reg)
    else $error("receive overflow not flagged");
  overflow_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_ovf_reg && !clr_rx |=> rx_ovf_reg)
    else $error("receive overflow dropped without clear");
  tx_overflow_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && tx_overflow_event |=> tx_ovf_reg)
    else $error("transmit overflow not flagged");
  tx_overflow_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_ovf_reg && !clr_tx |=> tx_ovf_reg)
    else $error("transmit overflow dropped without clear");
  rx_clear_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_rx |=> count_reg == '0)
    else $error("receive buffer not emptied");
  tx_clear_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_tx |=> clear_tx_buffer ##1 (!clear_tx_buffer || $past(clr_tx)))
    else $error("transmit clear pulse wrong");
  remote_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    remote_push_s |=> data_mem[$past(wr_ptr_reg)] == 512'h0)
    else $error("remote payload not zeroed");
  classic_dlc_a: assert property (@(posedge pclk) disable iff (!presetn)
    classic_push_s |=> dlc_mem[$past(wr_ptr_reg)] <= 4'h8)
    else $error("classic length code out of range");
  std_id_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && !rx_ext_id && rx_id > 29'h7FF |-> !push)
    else $error("oversized standard id stored");

  // Error state decode
  warn_any_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[BIT_WARN_ANY] == ((rx_error_count > 8'd95 && rx_error_count < 8'd128) ||
                                  (tx_error_count > 9'd95 && tx_error_count < 9'd128)))
    else $error("warning summary mismatch");
  rx_warn_band_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[BIT_WARN_RX] == (rx_error_count > 8'd95 && rx_error_count < 8'd128))
    else $error("receive warning band wrong");
  tx_warn_band_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[BIT_WARN_TX] == (tx_error_count > 9'd95 && tx_error_count < 9'd128))
    else $error("transmit warning band wrong");
  rx_passive_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[BIT_PASS_RX] == (rx_error_count > 8'd127))
    else $error("receive passive wrong");
  tx_passive_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[BIT_PASS_TX] == (tx_error_count > 9'd127))
    else $error("transmit passive wrong");
  bus_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg != MODE_CONFIG |-> status_word[BIT_BUS_OFF] == (tx_error_count > 9'd255))
    else $error("bus-off state wrong");
  config_busoff_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg == MODE_CONFIG |-> status_word[BIT_BUS_OFF])
    else $error("bus-off not forced in configuration");

  // Waiting count and timestamp
  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    push && !pop && !clr_rx |=> count_reg == $past(count_reg) + 1'b1)
    else $error("waiting count not advanced");
  count_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    pop_only_s |=> count_reg == $past(count_reg) - 1'b1)
    else $error("waiting count not reduced");
  empty_pop_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFF_POP && count_reg == '0 && !push |=> count_reg == '0)
    else $error("release of empty store changed count");
  stamp_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && tick_reg == PTR_W'(TICK_CYCLES - 1) |=> ts_reg == $past(ts_reg) + 64'h1)
    else $error("timestamp did not advance");
  stamp_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    push |=> ts_mem[$past(wr_ptr_reg)] == $past(ts_reg))
    else $error("frame timestamp not captured");

endmodule

// ==== sim/can_node_model.sv ====
// Far-side CAN node and protocol engine model: received frames and error counters
`timescale 1ns/1ps

module can_node_model (
  input  wire logic                      pclk,
  output logic                           rx_valid,
  output logic                           rx_ext_id,
  output logic [28:0]                    rx_id,
  output canfd_rx_pkg::frame_type_t      rx_type,
  output logic [3:0]                     rx_dlc,
  output logic [511:0]                   rx_data,
  output logic                           tx_overflow_event,
  output logic [8:0]                     tx_error_count,
  output logic [7:0]                     rx_error_count
);
  import canfd_rx_pkg::*;

  // ==========================================================
  // Idle values at time zero
  initial begin
    rx_valid = 1'b0;
    rx_ext_id = 1'b0;
    rx_id = '0;
    rx_type = FT_REMOTE;
    rx_dlc = 4'h0;
    rx_data = '0;
    tx_overflow_event = 1'b0;
    tx_error_count = 9'h000;
    rx_error_count = 8'h00;
  end

  // ==========================================================
  // One frame for one cycle; payload byte i is id low byte plus i
  task automatic send(input logic e, input logic [28:0] id, input frame_type_t t, input logic [3:0] d);
    logic [511:0] p;
    for (int i = 0; i < 64; i++) p[8*i +: 8] = id[7:0] + 8'(i);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_ext_id <= e;
    rx_id <= id;
    rx_type <= t;
    rx_dlc <= d;
    rx_data <= p;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~p; // Stale data and id lines never repeat the frame
    rx_id <= ~id;
  endtask

  // Transmit side overflow report, one cycle
  task automatic tx_ovf;
    @(posedge pclk);
    tx_overflow_event <= 1'b1;
    @(posedge pclk);
    tx_overflow_event <= 1'b0;
  endtask

  task automatic set_err(input logic [8:0] t, input logic [7:0] r);
    @(posedge pclk);
    tx_error_count <= t;
    rx_error_count <= r;
  endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the CAN FD receive status block
`timescale 1ns/1ps

module tb;
  import canfd_rx_pkg::*;

  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_en = 1'b1;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata;
  logic              pready, pslverr, rx_valid, rx_ext_id, tx_overflow_event, clear_tx_buffer;
  logic [28:0]       rx_id;
  frame_type_t       rx_type;
  op_mode_t          op_mode;
  logic [3:0]        rx_dlc;
  logic [511:0]      rx_data;
  logic [8:0]        tx_error_count;
  logic [7:0]        rx_error_count;
  int                bad_count = 0, checks = 0, ctx_n = 0;
  logic [8:0]        tec_v [9] = '{9'h000, 9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h000, 9'h000};
  logic [7:0]        rec_v [9] = '{8'h00, 8'h5F, 8'h00, 8'h7F, 8'h00, 8'h60, 8'h00, 8'h80, 8'hFF};

  always #50 pclk = ~pclk;
  // Count transmit clear pulses as they leave the block
  always @(posedge pclk) if (clear_tx_buffer === 1'b1) ctx_n++;

  canfd_rx_status_buffers dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_ext_id(rx_ext_id), .rx_id(rx_id),
    .rx_type(rx_type), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_overflow_event(tx_overflow_event),
    .tx_error_count(tx_error_count), .rx_error_count(rx_error_count),
    .clear_tx_buffer(clear_tx_buffer), .op_mode(op_mode));
  can_node_model node (.pclk(pclk), .rx_valid(rx_valid), .rx_ext_id(rx_ext_id), .rx_id(rx_id),
    .rx_type(rx_type), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_overflow_event(tx_overflow_event),
    .tx_error_count(tx_error_count), .rx_error_count(rx_error_count));

  // ==========================================================
  // Report, compare and APB master
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // ==========================================================
  // Expected values from the rules
  function automatic logic [31:0] status_exp(logic [8:0] t, logic [7:0] r);
    logic wrx, wtx;
    wrx = r > 95 && r < 128;
    wtx = t > 95 && t < 128;
    return {26'h0, t > 255, t > 127, r > 127, wtx, wrx, wrx | wtx};
  endfunction

  function automatic int nbytes(logic [3:0] d);
    int tbl [7] = '{12, 16, 20, 24, 32, 48, 64};
    return d <= 8 ? int'(d) : tbl[d - 9];
  endfunction

  // Frame i: every length code, both formats, all four types
  task automatic mk(input int i, output logic e, output logic [28:0] id, output frame_type_t t,
                    output logic [3:0] d);
    e = i[0];
    id = e ? 29'h1FFFFFF0 + 29'(i) : 29'h7FF - 29'(i);
    d = 4'(i);
    t = i == 0 ? FT_REMOTE : frame_type_t'(i > 8 ? 2 + i % 2 : 1 + i % 3);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    chk("op_mode", 32'(MODE_CONFIG), 32'(op_mode));
    rd(OFF_STATUS, q);
    chk("status in config", 32'h20, q);
    rd(OFF_RX_MESSAGE_COUNT, q);
    chk("message count", 32'h0, q);
    apb(1'b0, 12'h030, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask

  task automatic t_status;
    logic [31:0] q;
    wr(OFF_CTRL, 32'h0);
    for (int i = 0; i < 9; i++) begin
      node.set_err(tec_v[i], rec_v[i]);
      rd(OFF_STATUS, q);
      chk("status", status_exp(tec_v[i], rec_v[i]), q);
      rd(OFF_ERRCNT, q);
      chk("error counts", {15'h0, tec_v[i], rec_v[i]}, q);
    end
    wr(OFF_CTRL, 32'h3);
    node.set_err(9'h000, 8'h00);
    chk("op_mode config", 32'(MODE_CONFIG), 32'(op_mode));
    rd(OFF_STATUS, q);
    chk("config bus-off", 32'h20, q);
    wr(OFF_CTRL, 32'h0);
  endtask

  task automatic t_frames;
    logic [31:0] q, t0;
    logic e;
    logic [28:0] id;
    frame_type_t t;
    logic [3:0] d;
    logic [7:0] b;
    int n;
    for (int g = 0; g < 4; g++) begin
      for (int j = 0; j < 4; j++) begin
        mk(4 * g + j, e, id, t, d);
        node.send(e, id, t, d);
      end
      rd(OFF_RX_MESSAGE_COUNT, q);
      chk("message count", 32'h4, q);
      for (int j = 0; j < 4; j++) begin
        mk(4 * g + j, e, id, t, d);
        n = nbytes(d);
        rd(OFF_FRAME, q);
        chk("head frame", {t, e, id}, q);
        rd(OFF_BYTES, q);
        chk("byte count", {21'h0, d, 7'(n)}, q);
        if (n > 0 && n % 4 == 0 && t != FT_REMOTE) begin
          b = id[7:0] + 8'(n - 4);
          rd(OFF_DATA + 12'(n - 4), q);
          chk("payload word", {b + 8'h3, b + 8'h2, b + 8'h1, b}, q);
        end
        rd(OFF_TS_HI, q);
        chk("stamp high", 32'h0, q);
        rd(OFF_TS_LO, q);
        if (j == 0) t0 = q;
        chk("stamp step", t0 + 32'(2 * j), q);
        wr(OFF_POP, 32'h0);
      end
      rd(OFF_RX_MESSAGE_COUNT, q);
      chk("drained count", 32'h0, q);
    end
  endtask

  task automatic t_ovf;
    logic [31:0] q;
    int c;
    for (int i = 0; i < 5; i++) node.send(1'b0, 29'(16 + i), FT_CLASSIC, 4'h1);
    rd(OFF_RX_MESSAGE_COUNT, q);
    chk("full count", 32'h4, q);
    node.tx_ovf();
    rd(OFF_OVF, q);
    chk("both overflow", 32'h3, q);
    c = ctx_n;
    wr(OFF_CLEAR, 32'hFC);
    rd(OFF_RX_MESSAGE_COUNT, q);
    chk("count kept", 32'h4, q);
    rd(OFF_OVF, q);
    chk("overflow held", 32'h3, q);
    wr(OFF_CLEAR, 32'h1);
    rd(OFF_RX_MESSAGE_COUNT, q);
    chk("rx cleared", 32'h0, q);
    rd(OFF_OVF, q);
    chk("tx flag held", 32'h2, q);
    chk("no tx clear", 32'(c), 32'(ctx_n));
    wr(OFF_CLEAR, 32'h2);
    rd(OFF_OVF, q);
    chk("flags clear", 32'h0, q);
    chk("tx clear pulse", 32'(c + 1), 32'(ctx_n));
    node.send(1'b0, 29'h800, FT_CLASSIC, 4'h1);
    rd(OFF_RX_MESSAGE_COUNT, q);
    chk("bad std id", 32'h0, q);
  endtask

  // Clock enable low: no bus answer and no frame taken while frozen
  task automatic t_hold;
    logic [31:0] q;
    @(posedge pclk);
    clk_en <= 1'b0;
    node.send(1'b0, 29'h055, FT_CLASSIC, 4'h2);
    chk("pready frozen", 32'h0, {31'h0, pready});
    @(posedge pclk);
    clk_en <= 1'b1;
    rd(OFF_RX_MESSAGE_COUNT, q);
    chk("frozen count", 32'h0, q);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_frames();
    t_ovf();
    t_hold();
    conclude();
  end
endmodule
